// file: verilog/tslh_pkg.sv
/*
 * Package for the trigger sequencer limit and hold register bank: register
 * offsets, reset values, copy-step target codes and carrier structs.
 * Assumes a 32-bit classic Wishbone slave with word-aligned addresses.
 */
package tslh_pkg;

	// ------------------------------------------------------------------
	// register map
	// ------------------------------------------------------------------
	localparam int          TSLH_ADDR_W        = 4;
	localparam logic [3:0]  TSLH_OFF_C1_LIMIT  = 4'h0;  // counter_one_limit
	localparam logic [3:0]  TSLH_OFF_HOLD      = 4'h4;  // general_hold_word
	localparam logic [3:0]  TSLH_OFF_CTRL      = 4'h8;  // enable and run bits
	localparam logic [3:0]  TSLH_OFF_STATUS    = 4'hc;  // counter one state

	localparam logic [15:0] TSLH_C1_LIMIT_RST  = 16'h0000;
	localparam logic [15:0] TSLH_HOLD_RST      = 16'h0000;
	localparam logic [15:0] TSLH_CNT_RST       = 16'h0000;

	// control register bit positions
	localparam int          TSLH_CTRL_EN_BIT   = 0;
	localparam int          TSLH_CTRL_RUN_BIT  = 1;

	// ------------------------------------------------------------------
	// copy step targets
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		TSLH_TGT_TIMER_LIMIT,
		TSLH_TGT_COUNTER_LIMIT,
		TSLH_TGT_STEP_DELAY_LIMIT,
		TSLH_TGT_LITERAL_ZERO
	} tslh_target_t;

	// step commands from the execution engine
	typedef struct packed {
		logic         copy_hold_step;          // one-cycle pulse
		tslh_target_t copy_target;
		logic         index;                   // timer or counter number
		logic         counted_jump_step_one;   // one-cycle pulse
		logic         counter_one_step;        // counter one increment pulse
	} tslh_step_t;

	// copy strobe to the target registers
	typedef struct packed {
		logic         valid;
		tslh_target_t target;
		logic         index;
		logic [15:0]  data;
	} tslh_copy_t;

endpackage

// file: verilog/tslh_wb_slave.sv
/*
 * Classic Wishbone slave front end: decodes one access, acks it one cycle
 * after the request is seen and drops ack the cycle after.
 * Assumes a single master holding its request until ack.
 */
`timescale 1ns/100ps
module tslh_wb_slave (
	input  wire logic                          clk_sys,
	input  wire logic                          rst_b,
	input  wire logic                          clk_en,
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [tslh_pkg::TSLH_ADDR_W-1:0] wb_adr_i,
	output logic                               wb_ack,
	output logic                               wr_pulse,
	output logic                               rd_pulse,
	output logic [tslh_pkg::TSLH_ADDR_W-1:0]   acc_addr
);
	import tslh_pkg::*;

	// --------------------------------------------------------------
	// request detection
	// --------------------------------------------------------------
	wire req = wb_cyc_i & wb_stb_i & ~wb_ack;

	// ack stands one cycle; the pulses line up with it
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wb_ack   <= 1'b0;
			wr_pulse <= 1'b0;
			rd_pulse <= 1'b0;
			acc_addr <= '0;
		end else if (clk_en) begin
			wb_ack   <= req;
			wr_pulse <= req & wb_we_i;
			rd_pulse <= req & ~wb_we_i;
			acc_addr <= wb_adr_i;
		end
	end

endmodule

// file: verilog/tslh_regs.sv
/*
 * Trigger sequencer counter-one limit and general hold register bank.
 * Assumes the step engine gives one-cycle step pulses on clk_sys and that
 * software reaches the bank over classic Wishbone with 32-bit data.
 */
`timescale 1ns/100ps

// Operation
// R1: counted jump step one takes its loop count from counter_one_limit.
// R2: general counter one compares against counter_one_limit as its terminal value.
// R3: while enabled and running, software writes to both registers are ignored.
// R4: copy step moves general_hold_word into the selected limit or literal target.
// R5: general_hold_word is a full 16-bit read/write word, no reserved bits.
// R6: both registers clear on reset and hold until software or copy writes.
module tslh_regs (
	input  wire logic                          clk_sys,
	input  wire logic                          rst_b,
	input  wire logic                          clk_en,
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [tslh_pkg::TSLH_ADDR_W-1:0] wb_adr_i,
	input  wire logic [3:0]                    wb_sel_i,
	input  wire logic [31:0]                   wb_dat_i,
	output logic [31:0]                        wb_dat_o,
	output logic                               wb_ack_o,
	input  wire tslh_pkg::tslh_step_t          step_i,
	output tslh_pkg::tslh_copy_t               copy_o,
	output logic [15:0]                        jump_count_o,
	output logic                               jump_load_o,
	output logic                               c1_match_o,
	output logic                               sequencer_enable_o,
	output logic                               sequence_run_o
);
	import tslh_pkg::*;

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	logic [15:0]            counter_one_limit;
	logic [15:0]            general_hold_word;
	logic [15:0]            counter_one;
	logic                   wr_pulse;
	logic                   rd_pulse;
	logic [TSLH_ADDR_W-1:0] acc_addr;
	logic [31:0]            wdat;
	logic [3:0]             wsel;

	tslh_wb_slave u_slave (
		.clk_sys  (clk_sys),
		.rst_b    (rst_b),
		.clk_en   (clk_en),
		.wb_cyc_i (wb_cyc_i),
		.wb_stb_i (wb_stb_i),
		.wb_we_i  (wb_we_i),
		.wb_adr_i (wb_adr_i),
		.wb_ack   (wb_ack_o),
		.wr_pulse (wr_pulse),
		.rd_pulse (rd_pulse),
		.acc_addr (acc_addr)
	);

	// capture write data with the request so the ack cycle can commit it
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wdat <= '0;
			wsel <= '0;
		end else if (clk_en) begin
			wdat <= wb_dat_i;
			wsel <= wb_sel_i;
		end
	end

	// --------------------------------------------------------------
	// decode
	// --------------------------------------------------------------
	// a locked bank still acks writes; limit and hold write data is simply dropped
	wire locked    = sequencer_enable_o & sequence_run_o;               // [R3]
	wire wr_limit  = wr_pulse & (acc_addr == TSLH_OFF_C1_LIMIT) & ~locked; // [R3]
	wire wr_hold   = wr_pulse & (acc_addr == TSLH_OFF_HOLD) & ~locked;     // [R3]
	wire wr_ctrl   = wr_pulse & (acc_addr == TSLH_OFF_CTRL);
	wire c1_hit    = (counter_one == counter_one_limit);                // [R2]
	wire hold_copy = step_i.copy_hold_step & locked;
	// a copy aimed at counter one's limit lands in this bank and is also strobed out on copy_o
	wire copy_c1   = hold_copy & step_i.index &                         // [R4]
	                 (step_i.copy_target == TSLH_TGT_COUNTER_LIMIT);

	// byte-lane merge for the 16-bit registers
	wire [15:0] limit_merged = {wsel[1] ? wdat[15:8] : counter_one_limit[15:8],
	                            wsel[0] ? wdat[7:0]  : counter_one_limit[7:0]};
	wire [15:0] hold_merged  = {wsel[1] ? wdat[15:8] : general_hold_word[15:8],
	                            wsel[0] ? wdat[7:0]  : general_hold_word[7:0]}; // [R5]

	// read mux; unmapped offsets read zero
	wire [31:0] rd_data =
		(wb_adr_i == TSLH_OFF_C1_LIMIT) ? {16'h0000, counter_one_limit} :
		(wb_adr_i == TSLH_OFF_HOLD)     ? {16'h0000, general_hold_word} :
		(wb_adr_i == TSLH_OFF_CTRL)     ? {30'h00000000, sequence_run_o, sequencer_enable_o} :
		(wb_adr_i == TSLH_OFF_STATUS)   ? {15'h0000, c1_match_o, counter_one} :
		32'h00000000;

	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	// the two words hold their value unless a software write or a copy step lands
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			counter_one_limit <= TSLH_C1_LIMIT_RST;  // [R6]
			general_hold_word <= TSLH_HOLD_RST;      // [R6]
		end else if (clk_en) begin
			if (wr_limit) begin
				counter_one_limit <= limit_merged;
			end else if (copy_c1) begin
				counter_one_limit <= general_hold_word;  // [R4]
			end
			if (wr_hold) begin
				general_hold_word <= hold_merged;    // [R5]
			end
		end
	end

	// control bits; sequence_run only matters together with enable
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sequencer_enable_o <= 1'b0;
			sequence_run_o     <= 1'b0;
		end else if (clk_en && wr_ctrl && wsel[0]) begin
			sequencer_enable_o <= wdat[TSLH_CTRL_EN_BIT];
			sequence_run_o     <= wdat[TSLH_CTRL_RUN_BIT];
		end
	end

	// general counter one: counts steps, wraps to zero at the limit
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			counter_one <= TSLH_CNT_RST;
			c1_match_o  <= 1'b0;
		end else if (clk_en) begin
			if (!locked) begin
				counter_one <= TSLH_CNT_RST;
			end else if (step_i.counter_one_step) begin
				counter_one <= c1_hit ? TSLH_CNT_RST : counter_one + 16'h0001; // [R2]
			end
			c1_match_o <= locked & c1_hit;                                    // [R2]
		end
	end

	// step outputs: loop count and copy strobe
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			jump_count_o <= '0;
			jump_load_o  <= 1'b0;
			copy_o       <= '0;
		end else if (clk_en) begin
			jump_load_o   <= step_i.counted_jump_step_one & locked;
			if (step_i.counted_jump_step_one) begin
				jump_count_o <= counter_one_limit;    // [R1]
			end
			copy_o.valid  <= hold_copy;              // [R4]
			copy_o.target <= step_i.copy_target;
			copy_o.index  <= step_i.index;
			copy_o.data   <= general_hold_word;      // [R4]
		end
	end

	// read data registered on the request cycle, shown with ack
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wb_dat_o <= '0;
		end else if (clk_en) begin
			wb_dat_o <= rd_data;
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	a_limit_locked: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R3]
		(clk_en && locked && !copy_c1) |=> $stable(counter_one_limit))
		else $error("limit changed while sequencer running");

	a_hold_locked: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R3]
		(clk_en && locked) |=> $stable(general_hold_word))
		else $error("hold changed while sequencer running");

	a_jump_count: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R1]
		(clk_en && step_i.counted_jump_step_one && locked)
		|=> jump_load_o && jump_count_o == $past(counter_one_limit))
		else $error("jump loop count not taken from limit");

	a_copy_data: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R4]
		(clk_en && hold_copy) |=> copy_o.valid && copy_o.data == $past(general_hold_word))
		else $error("copy step did not carry hold word");

	a_match_flag: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R2]
		(clk_en && locked && counter_one == counter_one_limit) |=> c1_match_o)
		else $error("counter one match not flagged");

	a_hold_write: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R5]
		(clk_en && wr_hold && wsel[1:0] == 2'b11) |=> general_hold_word == $past(wdat[15:0]))
		else $error("hold word write lost bits");

	a_limit_keep: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R6]
		(clk_en && !wr_limit && !copy_c1) |=> $stable(counter_one_limit))
		else $error("limit changed without a write");

	a_copy_limit: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R4]
		(clk_en && copy_c1) |=> counter_one_limit == $past(general_hold_word))
		else $error("copy step missed counter one limit");

	a_read_ack: assert property (@(posedge clk_sys) disable iff (!rst_b) // read strobe comes with ack
		(clk_en && rd_pulse) |-> wb_ack_o && !wr_pulse)
		else $error("read strobe without ack");

	a_ack_pulse: assert property (@(posedge clk_sys) disable iff (!rst_b) // ack lasts one cycle
		(clk_en && wb_ack_o) |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

endmodule

// file: tb/testbench.sv
/*
 * Self-checking bench for the counter-one limit and hold register bank.
 * Assumes the top module tslh_regs and the package tslh_pkg from verilog/.
 */
`timescale 1ns/100ps
module testbench;
	import tslh_pkg::*;
	// ------------------------------------------------------------------
	// stimulus signals
	// ------------------------------------------------------------------
	logic        clk_sys = 1'b0;
	logic        rst_b   = 1'b0;
	logic        cyc     = 1'b0;
	logic        stb     = 1'b0;
	logic        we      = 1'b0;
	logic [3:0]  adr     = 4'h0;
	logic [3:0]  sel     = 4'h0;
	logic [31:0] dat     = 32'h0;
	logic [31:0] rdat;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	tslh_step_t  step    = '0;
	tslh_copy_t  copy_o;
	logic [15:0] jump_count_o;
	logic        jump_load_o;
	logic        c1_match_o;
	logic        clk_en  = 1'b1;
	logic        en_o;
	logic        run_o;
	int          mismatches = 0;
	int          n_compared = 0;
	always #10 clk_sys = ~clk_sys;
	tslh_regs DUT (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .step_i(step), .copy_o(copy_o),
		.jump_count_o(jump_count_o), .jump_load_o(jump_load_o), .c1_match_o(c1_match_o),
		.sequencer_enable_o(en_o), .sequence_run_o(run_o));
	// ------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------
	task automatic end_sim;
		if (mismatches == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one classic cycle; entered right after an edge, returns right after one
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) chk(32'h0, 32'h1);
		rdat = wb_dat_o;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		@(posedge clk_sys);
	endtask
	// one-cycle step pulse; outputs sampled at the edge ending cycle N+1
	task automatic pulse(input tslh_step_t s);
		step <= s;
		@(posedge clk_sys);
		step <= '0;
		@(posedge clk_sys);
	endtask
	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_reset_vals;
		wb(1'b0, TSLH_OFF_C1_LIMIT, 32'h0); chk(rdat, 32'h0);
		wb(1'b0, TSLH_OFF_HOLD, 32'h0);     chk(rdat, 32'h0);
	endtask
	task automatic t_rw;
		wb(1'b1, TSLH_OFF_HOLD, 32'h0000_ffff);
		wb(1'b0, TSLH_OFF_HOLD, 32'h0);     chk(rdat, 32'h0000_ffff);
		wb(1'b1, TSLH_OFF_HOLD, 32'h0000_a5c3);
		wb(1'b1, TSLH_OFF_C1_LIMIT, 32'h0000_0003);
		wb(1'b0, TSLH_OFF_HOLD, 32'h0);     chk(rdat, 32'h0000_a5c3);
		wb(1'b0, TSLH_OFF_C1_LIMIT, 32'h0); chk(rdat, 32'h0000_0003);
	endtask
	task automatic t_locked;
		wb(1'b1, TSLH_OFF_CTRL, 32'h3);
		wb(1'b1, TSLH_OFF_C1_LIMIT, 32'h0000_1234);
		wb(1'b1, TSLH_OFF_HOLD, 32'h0000_5678);
		wb(1'b0, TSLH_OFF_C1_LIMIT, 32'h0); chk(rdat, 32'h0000_0003);
		wb(1'b0, TSLH_OFF_HOLD, 32'h0);     chk(rdat, 32'h0000_a5c3);
	endtask
	task automatic t_jump;
		tslh_step_t s;
		s = '0;
		s.counted_jump_step_one = 1'b1;
		pulse(s);
		chk({31'h0, jump_load_o}, 32'h1);
		chk({16'h0, jump_count_o}, 32'h3);
	endtask
	task automatic t_copy;
		tslh_step_t s;
		for (int i = 0; i < 4; i++) begin
			s = '0;
			s.copy_hold_step = 1'b1;
			s.copy_target = tslh_target_t'(i);
			// index kept off counter one so its limit survives for the counter scenario
			s.index = ~i[0];
			pulse(s);
			chk(32'(copy_o), 32'({1'b1, tslh_target_t'(i), ~i[0], 16'ha5c3}));
		end
	endtask
	task automatic t_counter;
		tslh_step_t s;
		s = '0;
		s.counter_one_step = 1'b1;
		for (int i = 0; i < 3; i++)
			pulse(s);
		@(posedge clk_sys);
		chk({31'h0, c1_match_o}, 32'h1);
		wb(1'b0, TSLH_OFF_STATUS, 32'h0); chk(rdat, 32'h0001_0003);
		pulse(s);
		wb(1'b0, TSLH_OFF_STATUS, 32'h0); chk(rdat, 32'h0);
		wb(1'b1, TSLH_OFF_CTRL, 32'h0);
		wb(1'b1, TSLH_OFF_C1_LIMIT, 32'h0000_0007);
		wb(1'b0, TSLH_OFF_C1_LIMIT, 32'h0); chk(rdat, 32'h0000_0007);
	endtask
	// locked again: control readback, clock-enable freeze, copy into counter one's limit
	task automatic t_freeze;
		tslh_step_t s;
		s = '0;
		s.counter_one_step = 1'b1;
		wb(1'b1, TSLH_OFF_CTRL, 32'h3);
		wb(1'b0, TSLH_OFF_CTRL, 32'h0); chk(rdat, 32'h3);
		chk({30'h0, run_o, en_o}, 32'h3);
		clk_en <= 1'b0;
		pulse(s);
		clk_en <= 1'b1;
		wb(1'b0, TSLH_OFF_STATUS, 32'h0); chk(rdat, 32'h0);
		pulse(s);
		wb(1'b0, TSLH_OFF_STATUS, 32'h0); chk(rdat, 32'h0000_0001);
		s = '0;
		s.copy_hold_step = 1'b1;
		s.copy_target = TSLH_TGT_COUNTER_LIMIT;
		s.index = 1'b1;
		pulse(s);
		wb(1'b0, TSLH_OFF_C1_LIMIT, 32'h0); chk(rdat, 32'h0000_a5c3);
	endtask
	// ------------------------------------------------------------------
	// main sequence and watchdog; whole run is about a hundred cycles
	// ------------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		t_reset_vals();
		t_rw();
		t_locked();
		t_jump();
		t_copy();
		t_counter();
		t_freeze();
		end_sim();
	end
	initial begin
		#100000;
		mismatches++;
		end_sim();
	end
endmodule
